// ==== verification/gpc_board.sv ====
// Board model: each pin follows its pad driver, else its pull-up, else the outside level.
// Assumes gpc_pkg is compiled first; outside levels are weak next to a pull-up.
`default_nettype none
module gpc_board (
	input  wire gpc_pkg::gpc_pad_t  pad_i [3],
	input  wire gpc_pkg::gpc_byte_t ext_i [3],
	output var  gpc_pkg::gpc_byte_t pin_o [3]
);
	timeunit 1ns;
	timeprecision 1ps;
	always_comb begin
		for (int p = 0; p < 3; p++) begin
			pin_o[p] = (pad_i[p].out_en & pad_i[p].out_val)
				| (~pad_i[p].out_en & (pad_i[p].pull_up_en | ext_i[p]));
		end
	end
endmodule : gpc_board
`default_nettype wire

// ==== verification/gpc_pin_control_tb.sv ====
// Self-checking bench for gpc_pin_control with a board model on the pins.
// Assumes gpc_pkg, gpc_pin_control and gpc_board are compiled first.
`default_nettype none
module gpc_pin_control_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic               core_clk_i, rst_n_i, dbg;
	logic [2:0]         rd, irq;
	gpc_pkg::gpc_cfg_t  cfg [3];
	gpc_pkg::gpc_byte_t ana, per [3], ext [3], pin [3], lvl [3], pnd [3], old [3], pe [3];
	gpc_pkg::gpc_pad_t  pad [3], sp;
	int                 err_count, total_checks, seed;
	gpc_pin_control i_dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .cfg_i(cfg),
		.analog_input_disable_i(ana), .debug_enable_input_i(dbg), .periph_out_i(per),
		.pad_in_i(pin), .level_read_i(rd), .pad_o(pad), .level_o(lvl), .pending_o(pnd),
		.irq_o(irq));
	gpc_board i_board (.pad_i(pad), .ext_i(ext), .pin_o(pin));
	initial begin
		core_clk_i = 1'b0;
		forever #2 core_clk_i = ~core_clk_i;
	end
	// ----------------------------------------
	// Expectations and checks
	// ----------------------------------------
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		total_checks++;
		if (s !== e) begin
			err_count++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	function automatic gpc_pkg::gpc_byte_t dbm(int p);
		return (p == 1 && dbg) ? 8'hc0 : 8'h00;
	endfunction : dbm
	// Out_val only matters while the pin is driven, so it is compared masked
	function automatic gpc_pkg::gpc_pad_t epad(int p);
		gpc_pkg::gpc_byte_t dr;
		gpc_pkg::gpc_byte_t sel;
		dr = cfg[p].direction & ~dbm(p);
		sel = cfg[p].peripheral_output_select;
		return {((sel & per[p]) | (~sel & cfg[p].drive_value)) & dr, dr,
			~cfg[p].direction & cfg[p].drive_value & ~dbm(p)};
	endfunction : epad
	function automatic gpc_pkg::gpc_byte_t elvl(int p);
		gpc_pkg::gpc_pad_t e;
		e = epad(p);
		return (e.out_val | (~e.out_en & (e.pull_up_en | ext[p]))) & ~dbm(p)
			& ~((p == 0) ? ana : 8'h00);
	endfunction : elvl
	task automatic end_of_test;
		$display("Checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : end_of_test
	initial begin
		seed = 32'hd438_e932;
		{err_count, total_checks, rst_n_i, rd, dbg, ana} = '0;
		for (int p = 0; p < 3; p++) {cfg[p], per[p], ext[p]} = '0;
		repeat (5) @(negedge core_clk_i);
		rst_n_i = 1'b1;
		for (int t = 0; t < 30; t++) begin
			for (int p = 0; p < 3; p++) begin
				cfg[p] = $random(seed);
				per[p] = 8'($random(seed));
				ext[p] = 8'($random(seed));
			end
			ana = (t == 1) ? 8'hff : ((t == 2) ? 8'h00 : 8'($random(seed)));
			dbg = (t < 2) ? t[0] : 1'($random(seed));
			repeat (5) @(negedge core_clk_i);
			for (int p = 0; p < 3; p++) begin
				sp = pad[p];
				sp.out_val = sp.out_val & sp.out_en;
				chk("pad", epad(p), sp);
				chk("level", elvl(p), lvl[p]);
				cfg[p].change_interrupt_enable = 8'hff;
				old[p] = elvl(p);
			end
			rd = 3'h7;
			@(negedge core_clk_i);
			rd = 3'h0;
			@(negedge core_clk_i);
			for (int p = 0; p < 3; p++) chk("pending", '0, pnd[p]);
			chk("irq", '0, irq);
			for (int p = 0; p < 3; p++) begin
				ext[p] = 8'($random(seed));
				cfg[p].change_interrupt_enable = (t == 3) ? 8'h00 : 8'($random(seed));
			end
			repeat (2) @(negedge core_clk_i);
			// Two edges in, the change is still inside the synchroniser
			for (int p = 0; p < 3; p++) chk("level", old[p], lvl[p]);
			@(negedge core_clk_i);
			for (int p = 0; p < 3; p++) begin
				chk("level", elvl(p), lvl[p]);
				pe[p] = (old[p] ^ elvl(p)) & cfg[p].change_interrupt_enable;
				chk("pending", pe[p], pnd[p]);
				chk("irq", |pe[p], irq[p]);
				// A read only clears the bits whose enable is still set
				cfg[p].change_interrupt_enable = 8'($random(seed));
			end
			rd = 3'h7;
			@(negedge core_clk_i);
			rd = 3'h0;
			@(negedge core_clk_i);
			for (int p = 0; p < 3; p++) begin
				chk("pending", pe[p] & ~cfg[p].change_interrupt_enable, pnd[p]);
			end
			chk("irq", '0, irq);
			$display("Test %0d done", t);
		end
		rst_n_i = 1'b0;
		repeat (2) @(negedge core_clk_i);
		for (int p = 0; p < 3; p++) chk("reset", '0, {pad[p], lvl[p] | pnd[p]});
		chk("reset", '0, irq);
		end_of_test();
	end
endmodule : gpc_pin_control_tb
`default_nettype wire

// ==== verilog/gpc_consts.svh ====
// Constants for the general purpose pin control block.
// Assumes inclusion by gpc_pkg.sv and gpc_pin_control.sv only.
`ifndef GPC_CONSTS_SVH
`define GPC_CONSTS_SVH

`define GPC_PORT_WIDTH 8
`define GPC_NUM_PORTS  3
`define GPC_PORT_A     0
`define GPC_PORT_B     1
`define GPC_PORT_C     2
`define GPC_DBG_HI_BIT 7
`define GPC_DBG_LO_BIT 6
`define GPC_RST_CFG    8'h00

`endif

// ==== verilog/gpc_pin_control.sv ====
// Pin control for three eight-bit ports: pad drive, pull-ups, readback and
// level-change interrupts. Configuration arrives as plain ports; the reading
// agent pulses a per-port strobe when it reads the level readback.
`include "gpc_consts.svh"
`default_nettype none

module gpc_pin_control #(
	parameter int PORT_WIDTH = `GPC_PORT_WIDTH
) (
	input  wire logic                    core_clk_i,
	input  wire logic                    rst_n_i,
	input  wire gpc_pkg::gpc_cfg_t       cfg_i [`GPC_NUM_PORTS],
	input  wire gpc_pkg::gpc_byte_t      analog_input_disable_i,
	input  wire logic                    debug_enable_input_i,
	input  wire gpc_pkg::gpc_byte_t      periph_out_i [`GPC_NUM_PORTS],
	input  wire gpc_pkg::gpc_byte_t      pad_in_i [`GPC_NUM_PORTS],
	input  wire logic [`GPC_NUM_PORTS-1:0] level_read_i,
	output var  gpc_pkg::gpc_pad_t       pad_o [`GPC_NUM_PORTS],
	output var  gpc_pkg::gpc_byte_t      level_o [`GPC_NUM_PORTS],
	output var  gpc_pkg::gpc_byte_t      pending_o [`GPC_NUM_PORTS],
	output var  logic [`GPC_NUM_PORTS-1:0] irq_o
);

	// ------------------------------------------------------------
	// Elaboration checks
	// ------------------------------------------------------------
	// The byte type is fixed by the package, so only that width can be served
	if (PORT_WIDTH != `GPC_PORT_WIDTH) begin : g_width_check
		$error("gpc_pin_control: PORT_WIDTH must equal the port byte width");
	end

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	gpc_pkg::gpc_pad_t  pad_r     [`GPC_NUM_PORTS];
	gpc_pkg::gpc_pad_t  pad_nxt   [`GPC_NUM_PORTS];
	gpc_pkg::gpc_byte_t sync1_r   [`GPC_NUM_PORTS];
	gpc_pkg::gpc_byte_t sync2_r   [`GPC_NUM_PORTS];
	gpc_pkg::gpc_byte_t level_r   [`GPC_NUM_PORTS];
	gpc_pkg::gpc_byte_t level_nxt [`GPC_NUM_PORTS];
	gpc_pkg::gpc_byte_t pend_r    [`GPC_NUM_PORTS];
	gpc_pkg::gpc_byte_t pend_nxt  [`GPC_NUM_PORTS];
	logic [`GPC_NUM_PORTS-1:0] irq_r;
	logic [`GPC_NUM_PORTS-1:0] irq_nxt;

	// Pins lost to the debugger: port B upper two bits while debug is on
	gpc_pkg::gpc_byte_t dbg_mask;

	// ------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------
	always_comb begin
		gpc_pkg::gpc_byte_t gate;
		gpc_pkg::gpc_byte_t live;
		gate = '0;
		live = '0;
		dbg_mask = '0;
		if (debug_enable_input_i) begin
			dbg_mask[`GPC_DBG_HI_BIT] = 1'b1;
			dbg_mask[`GPC_DBG_LO_BIT] = 1'b1;
		end
		for (int p = 0; p < `GPC_NUM_PORTS; p++) begin
			gate = (p == `GPC_PORT_B) ? dbg_mask : '0;
			// Output enable follows direction; debug pins are released
			pad_nxt[p].out_en = cfg_i[p].direction & ~gate;
			pad_nxt[p].out_val = (cfg_i[p].peripheral_output_select & periph_out_i[p])
				| (~cfg_i[p].peripheral_output_select & cfg_i[p].drive_value);
			pad_nxt[p].pull_up_en = ~cfg_i[p].direction & cfg_i[p].drive_value
				& ~gate;
			// Disabled analog inputs read as zero and never toggle
			if (p == `GPC_PORT_A) begin
				gate = gate | analog_input_disable_i;
			end
			live = sync2_r[p] & ~gate;
			level_nxt[p] = live;
			// Set wins over the read clear so no edge is lost
			pend_nxt[p] = pend_r[p];
			if (level_read_i[p]) begin
				pend_nxt[p] = pend_r[p] & ~cfg_i[p].change_interrupt_enable;
			end
			pend_nxt[p] = pend_nxt[p] | ((live ^ level_r[p])
				& cfg_i[p].change_interrupt_enable);
			irq_nxt[p] = |(pend_nxt[p] & cfg_i[p].change_interrupt_enable);
		end
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge core_clk_i) begin
		for (int p = 0; p < `GPC_NUM_PORTS; p++) begin
			if (!rst_n_i) begin
				pad_r[p]   <= '0;
				sync1_r[p] <= `GPC_RST_CFG;
				sync2_r[p] <= `GPC_RST_CFG;
				level_r[p] <= `GPC_RST_CFG;
				pend_r[p]  <= `GPC_RST_CFG;
			end else begin
				pad_r[p]   <= pad_nxt[p];
				sync1_r[p] <= pad_in_i[p];
				sync2_r[p] <= sync1_r[p];
				level_r[p] <= level_nxt[p];
				pend_r[p]  <= pend_nxt[p];
			end
		end
		if (!rst_n_i) begin
			irq_r <= '0;
		end else begin
			irq_r <= irq_nxt;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	// Plain copies of the flops, so no output carries a combinational path
	always_comb begin
		for (int p = 0; p < `GPC_NUM_PORTS; p++) begin
			pad_o[p]     = pad_r[p];
			level_o[p]   = level_r[p];
			pending_o[p] = pend_r[p];
		end
		irq_o = irq_r;
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);

	// Pad control, one cycle behind the configuration
	dir_output_a: assert property (cfg_i[0].direction[0] |=> pad_r[0].out_en[0])
		else $error("output enable missing for direction set");
	dir_input_a: assert property (!cfg_i[2].direction[3] |=> !pad_r[2].out_en[3])
		else $error("input pin still driven");
	periph_sel_a: assert property (cfg_i[1].peripheral_output_select[2]
		|=> pad_r[1].out_val[2] == $past(periph_out_i[1][2]))
		else $error("peripheral output not routed");
	soft_drive_a: assert property (!cfg_i[0].peripheral_output_select[4]
		|=> pad_r[0].out_val[4] == $past(cfg_i[0].drive_value[4]))
		else $error("software drive value not applied");
	pull_up_a: assert property (!cfg_i[2].direction[1] && cfg_i[2].drive_value[1]
		|=> pad_r[2].pull_up_en[1])
		else $error("pull-up not enabled");
	pull_off_a: assert property (cfg_i[2].direction[1] |=> !pad_r[2].pull_up_en[1])
		else $error("pull-up left on a driven pin");

	// Debug takes port B bits 7 and 6 away completely, and only while it is on
	debug_take_a: assert property (debug_enable_input_i
		|=> !pad_r[1].out_en[7] && !pad_r[1].out_en[6])
		else $error("debug pins still driven");
	debug_pull_a: assert property (debug_enable_input_i
		|=> !pad_r[1].pull_up_en[7] && !pad_r[1].pull_up_en[6])
		else $error("debug pins still pulled up");
	debug_read_a: assert property (debug_enable_input_i
		|=> !level_r[1][7] && !level_r[1][6])
		else $error("debug pins still read back");
	debug_free_a: assert property (!debug_enable_input_i && cfg_i[1].direction[7]
		|=> pad_r[1].out_en[7])
		else $error("port B pin lost without debug");

	// Input path: two synchroniser stages, then the readback register
	analog_off_a: assert property (analog_input_disable_i[5] |=> !level_r[0][5])
		else $error("analog pin digital path still live");
	sequence pin_rise_s;
		!pad_in_i[0][1] ##1 pad_in_i[0][1];
	endsequence
	sequence port_a_open_s;
		(debug_enable_input_i == 1'b0 && analog_input_disable_i[1] == 1'b0) [*3];
	endsequence
	change_sync_a: assert property (pin_rise_s ##0 port_a_open_s
		|=> level_r[0][1])
		else $error("level not seen after two sync stages");
	sequence pin_low_s;
		!pad_in_i[0][1] [*2];
	endsequence
	sync_delay_a: assert property (pin_low_s ##1 pad_in_i[0][1]
		|=> !level_r[0][1] ##1 !level_r[0][1])
		else $error("level seen before two sync stages");

	// Pending bits: set by an enabled change, cleared only by an enabled read
	no_enable_a: assert property (!cfg_i[2].change_interrupt_enable[0]
		|=> !pend_r[2][0] || $past(pend_r[2][0]))
		else $error("pending set without enable");
	change_set_a: assert property (cfg_i[2].change_interrupt_enable[6]
		&& (level_nxt[2][6] != level_r[2][6]) |=> pend_r[2][6])
		else $error("level change not recorded");
	pend_hold_a: assert property (pend_r[0][3] && !level_read_i[0] |=> pend_r[0][3])
		else $error("pending bit lost without a read");
	read_clear_a: assert property (level_read_i[1]
		&& cfg_i[1].change_interrupt_enable[0]
		&& level_nxt[1][0] == level_r[1][0] |=> !pend_r[1][0])
		else $error("readback did not clear pending");
	read_keep_a: assert property (level_read_i[0]
		&& !cfg_i[0].change_interrupt_enable[3] && pend_r[0][3] |=> pend_r[0][3])
		else $error("read cleared a disabled pending bit");

	// Interrupt line, registered alongside the pending bits
	irq_merge_a: assert property (irq_r[2] == |(pend_r[2]
		& $past(cfg_i[2].change_interrupt_enable)))
		else $error("interrupt line disagrees with pending bits");
	sequence enabled_change_s;
		cfg_i[1].change_interrupt_enable[0] && level_nxt[1][0] != level_r[1][0];
	endsequence
	irq_raise_a: assert property (enabled_change_s |=> irq_r[1])
		else $error("enabled change raised no interrupt");
	irq_mask_a: assert property (cfg_i[0].change_interrupt_enable == '0
		|=> !irq_r[0])
		else $error("interrupt raised with all enables clear");
	sequence full_read_s;
		level_read_i[2] && cfg_i[2].change_interrupt_enable == 8'hff
			&& level_nxt[2] == level_r[2];
	endsequence
	irq_clear_a: assert property (full_read_s |=> !irq_r[2] && pend_r[2] == '0)
		else $error("read left the interrupt raised");

	// Checked while reset is held, so it carries its own disable clause
	reset_clear_a: assert property (disable iff (1'b0) !rst_n_i
		|=> pad_r[1] == '0 && pend_r[1] == '0 && level_r[1] == '0 && irq_r == '0)
		else $error("state not cleared by reset");

endmodule : gpc_pin_control

`default_nettype wire

// ==== verilog/gpc_pkg.sv ====
// Types for the general purpose pin control block.
// Assumes gpc_consts.svh is on the include path.
`include "gpc_consts.svh"
`default_nettype none

package gpc_pkg;
	typedef logic [`GPC_PORT_WIDTH-1:0] gpc_byte_t;

	// Per-port configuration as software holds it
	typedef struct packed {
		gpc_byte_t direction;
		gpc_byte_t peripheral_output_select;
		gpc_byte_t drive_value;
		gpc_byte_t change_interrupt_enable;
	} gpc_cfg_t;

	// Per-port pad control toward the pin drivers
	typedef struct packed {
		gpc_byte_t out_val;
		gpc_byte_t out_en;
		gpc_byte_t pull_up_en;
	} gpc_pad_t;
endpackage : gpc_pkg

`default_nettype wire
